// ==== inc/rpi_regs.svh ====
// Constants for the repeater PHY port interface: port count, widths, codes.
// Assumes inclusion by bare name from the package and design files.
`ifndef RPI_REGS_SVH
`define RPI_REGS_SVH

`define RPI_NUM_PORTS     12
`define RPI_NIB_W         4
`define RPI_ERR_CODE_VIOL 4'h0
`define RPI_ERR_CODE_EBUF 4'h1
`define RPI_ERR_CODE_TERM 4'h2
`define RPI_ERR_CODE_RSVD 4'h3
`define RPI_ERR_CODE_10MB 4'h4

`endif

// ==== inc/rpi_pkg.sv ====
// Types shared by the repeater PHY port interface design.
// Assumes rpi_regs.svh is on the include path.
`include "rpi_regs.svh"
package rpi_pkg;
  typedef logic [`RPI_NUM_PORTS-1:0] rpi_port_vec_t;
  typedef logic [`RPI_NIB_W-1:0]     rpi_nibble_t;
  typedef enum logic [1:0] {
    RPI_IDLE = 2'b00,
    RPI_SEL  = 2'b01,
    RPI_HOLD = 2'b11
  } rpi_sel_state_t;
endpackage : rpi_pkg

// ==== verilog/rpi_rx_sample.sv ====
// Receive sampler on the PHY receive clock; its toggle feeds the core-clock crossing in rpi_phy_port.
// Assumes the PHY changes its outputs on the falling receive clock edge.
`timescale 1ns/1ps
module rpi_rx_sample (
  input  wire logic              rx_clk,     // Receive clock from PHY
  input  wire logic              rx_rst,     // Reset synced to rx_clk
  input  wire rpi_pkg::rpi_nibble_t rxd,     // Shared receive nibble
  input  wire logic              rx_dv,      // Receive data valid
  input  wire logic              rx_er,      // Receive error
  output logic                   smp_tgl,    // Toggles per sampled nibble
  output rpi_pkg::rpi_nibble_t   smp_nib,    // Sampled nibble
  output logic                   smp_er      // Sampled error flag
);
  import rpi_pkg::*;

  rpi_nibble_t nib_q, nib_d;
  logic        er_q, er_d, tgl_q, tgl_d;

  // Rising-edge capture sits mid-way between falling-edge updates.
  always_comb begin
    nib_d = nib_q;
    er_d  = er_q;
    tgl_d = tgl_q;
    if (rx_dv || rx_er) begin
      nib_d = rxd;
      er_d  = rx_er;
      tgl_d = ~tgl_q;
    end
  end

  always_ff @(posedge rx_clk) begin
    if (rx_rst) begin
      nib_q <= 4'h0;
      er_q  <= 1'b0;
      tgl_q <= 1'b0;
    end else begin
      nib_q <= nib_d;
      er_q  <= er_d;
      tgl_q <= tgl_d;
    end
  end

  assign smp_tgl = tgl_q;
  assign smp_nib = nib_q;
  assign smp_er  = er_q;
endmodule : rpi_rx_sample

// ==== verilog/rpi_phy_port.sv ====
// PHY side of a twelve-port repeater: receive select, sampling, transmit.
// Assumes a core clock plus the receive clock of the selected PHY chip.
//
// Contract
// - Shared 4-bit receive bus, enabled port only
// - Twelve per-port receive enable outputs
// - Strap high active high, low active low
// - Error nibble encodes error type codes
// - Error state goes only to repeater bus
// - Enable receive only while carrier asserted; in reset a low strap leaves every pin active
// - Twelve asynchronous active-high carrier inputs
// - Twelve active-high per-port transmit enables
// - Transmit busy is OR of enables
// - Transmit error marks code violation nibble
// - Shared 4-bit transmit nibble output
`timescale 1ns/1ps
`include "rpi_regs.svh"
module rpi_phy_port (
  input  wire logic                  clk,          // Core clock, 25 MHz
  input  wire logic                  rst,          // Sync reset, high
  input  wire logic                  rx_clk,       // PHY receive clock
  input  wire logic                  rx_rst,       // Reset on rx_clk
  input  wire rpi_pkg::rpi_nibble_t  rxd,          // Shared receive nibble
  input  wire logic                  rx_dv,        // Receive data valid
  input  wire logic                  rx_er,        // Receive error
  input  wire rpi_pkg::rpi_port_vec_t crs,         // Async carrier per port
  input  wire logic                  receive_enable_polarity_strap, // Strap
  output rpi_pkg::rpi_port_vec_t     port_receive_output_enable, // To PHYs
  input  wire rpi_pkg::rpi_port_vec_t tx_port_req, // Ports to transmit
  input  wire rpi_pkg::rpi_nibble_t  tx_nib_in,    // Nibble to transmit
  input  wire logic                  tx_viol_in,   // Send code violation
  output rpi_pkg::rpi_port_vec_t     port_transmit_enable, // To PHYs
  output logic                       tx_busy,      // Transmit in progress
  output logic                       tx_er,        // Transmit error
  output rpi_pkg::rpi_nibble_t       txd,          // Shared transmit nibble
  output logic                       ir_valid,     // Nibble to repeater bus
  output rpi_pkg::rpi_nibble_t       ir_nib,       // Nibble, repeater bus
  output logic                       ir_err,       // Error, repeater bus
  output logic [3:0]                 rx_port       // Selected port number
);
  import rpi_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Carrier synchroniser and polarity strap capture.

  rpi_port_vec_t crs_s_q;
  logic          strap_m_q, strap_m_d, strap_s_q, strap_s_d;
  logic          pol_q, pol_d;
  logic          strap_done_q, strap_done_d;

  // Every carrier bit is asynchronous to clk and to every other bit, so
  // each one has its own two-flop chain. Only the second stage is read by
  // any logic; the first stage is allowed to go metastable.
  for (genvar g = 0; g < `RPI_NUM_PORTS; g++) begin : g_crs_sync
    logic m_q, m_d;
    logic s_q, s_d;

    always_comb begin
      m_d = crs[g];
      s_d = m_q;
    end

    always_ff @(posedge clk) begin
      m_q <= m_d;
      s_q <= s_d;
    end

    assign crs_s_q[g] = s_q;
  end : g_crs_sync

  // The strap is a pin as well and passes the same two stages.
  always_comb begin
    strap_m_d = receive_enable_polarity_strap;
    strap_s_d = strap_m_q;
  end

  always_ff @(posedge clk) begin
    strap_m_q <= strap_m_d;
    strap_s_q <= strap_s_d;
  end

  // The strap is latched once after reset release; high means active high.
  // A strap change after that waits for the next reset.
  always_comb begin
    pol_d        = pol_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      pol_d = strap_s_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pol_q        <= 1'b1;
      strap_done_q <= 1'b0;
    end else begin
      pol_q        <= pol_d;
      strap_done_q <= strap_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive port selection: one port at a time, only while carrier.
  // A port keeps the bus until its own carrier drops, whatever others do.

  rpi_sel_state_t state_q, state_d;
  logic [3:0]     sel_q, sel_d, first_idx;
  logic           any_crs, sel_ok;
  rpi_port_vec_t  rxe_q, rxe_d;

  // Lowest-index port with synced carrier wins; the loop runs downward so
  // that the last hit it records is the lowest index.
  always_comb begin
    first_idx = 4'h0;
    for (int i = `RPI_NUM_PORTS - 1; i >= 0; i--) begin
      if (crs_s_q[i]) begin
        first_idx = 4'(i);
      end
    end
  end

  assign any_crs = |crs_s_q;

  // The index register is four bits wide but only twelve codes name a
  // port; anything else is treated as no selection at all.
  assign sel_ok = (sel_q < 4'(`RPI_NUM_PORTS));

  always_comb begin
    state_d = state_q;
    sel_d   = sel_q;
    unique case (state_q)
      RPI_IDLE: begin
        if (any_crs) begin
          sel_d   = first_idx;
          state_d = RPI_SEL;
        end
      end
      RPI_SEL: begin
        state_d = RPI_HOLD;
      end
      RPI_HOLD: begin
        if (!sel_ok || !crs_s_q[sel_q]) begin
          state_d = RPI_IDLE;
        end
      end
      // The unused code sends the machine back to idle.
      default: begin
        state_d = RPI_IDLE;
      end
    endcase
  end

  // A single bit of the enable vector can ever be set. The enable stays all
  // idle for at least two cycles between ports, so two chips share the bus only in reset with a low strap.
  always_comb begin
    rxe_d = '0;
    if ((state_q == RPI_HOLD || state_q == RPI_SEL) && sel_ok) begin
      if (crs_s_q[sel_q]) begin
        rxe_d[sel_q] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RPI_IDLE;
      sel_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      sel_q   <= sel_d;
    end
  end

  // Each enable pin has a flop of its own, so no pin glitches while the
  // selection settles. The active level follows the latched strap and the
  // inactive level is the opposite, which keeps a chip whose pin is
  // inactive off the shared receive bus.
  for (genvar p = 0; p < `RPI_NUM_PORTS; p++) begin : g_rx_en_pin
    logic en_q, en_d;

    always_comb begin
      en_d = rxe_d[p];
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        en_q <= 1'b0;
      end else begin
        en_q <= en_d;
      end
    end

    assign rxe_q[p]                      = en_q;
    assign port_receive_output_enable[p] = pol_q ? en_q : ~en_q;
  end : g_rx_en_pin

  assign rx_port = sel_q;

  ////////////////////////////////////////////////////////////////////////
  // Receive sampling on the PHY clock and crossing to the core clock.

  logic        smp_tgl, tgl_m_q, tgl_s_q, tgl_p_q, tgl_evt;
  logic        tgl_m_d, tgl_s_d, tgl_p_d;
  rpi_nibble_t smp_nib, ir_nib_q, ir_nib_d;
  logic        smp_er, ir_err_q, ir_err_d, ir_val_q, ir_val_d;

  // The sampler runs on the clock of whichever chip is enabled; only its
  // toggle, nibble and flag leave that domain.
  rpi_rx_sample u_rx_sample (
    .rx_clk  (rx_clk),
    .rx_rst  (rx_rst),
    .rxd     (rxd),
    .rx_dv   (rx_dv),
    .rx_er   (rx_er),
    .smp_tgl (smp_tgl),
    .smp_nib (smp_nib),
    .smp_er  (smp_er)
  );

  // The sample toggle crosses into clk through two flops; a third flop
  // remembers the last value seen so that each change gives one event.
  // Only the second stage of the pair is read by anything else.
  always_comb begin
    tgl_m_d = smp_tgl;
    tgl_s_d = tgl_m_q;
    tgl_p_d = tgl_s_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_p_q <= 1'b0;
    end else begin
      tgl_m_q <= tgl_m_d;
      tgl_s_q <= tgl_s_d;
      tgl_p_q <= tgl_p_d;
    end
  end

  assign tgl_evt = tgl_s_q != tgl_p_q;

  ////////////////////////////////////////////////////////////////////////
  // Repeater-bus outputs: one held nibble per sample, and one pulse if a port is enabled.

  // The sampled nibble and flag are read only once the toggle has landed,
  // by which time they have stood still for two clk cycles. A new sample
  // must not follow within about three clk cycles or the older is lost;
  // the receive clock must therefore run below about a third of the 25 MHz clk rate.
  always_comb begin
    ir_val_d = 1'b0;
    ir_nib_d = ir_nib_q;
    ir_err_d = ir_err_q;
    if (tgl_evt) begin
      // Nibbles arriving while no port is enabled raise no pulse.
      ir_val_d = |rxe_q;
      ir_nib_d = smp_nib;
      // Error code travels only on the repeater-bus outputs.
      ir_err_d = smp_er;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ir_val_q <= 1'b0;
      ir_nib_q <= 4'h0;
      ir_err_q <= 1'b0;
    end else begin
      ir_val_q <= ir_val_d;
      ir_nib_q <= ir_nib_d;
      ir_err_q <= ir_err_d;
    end
  end

  assign ir_valid = ir_val_q;
  assign ir_nib   = ir_nib_q;
  assign ir_err   = ir_err_q;

  ////////////////////////////////////////////////////////////////////////
  // Transmit path: registered enables, nibble and violation marker.

  rpi_nibble_t   txd_q, txd_d;
  logic          txer_q, txer_d;
  logic          busy_q, busy_d;

  // Each port enable has its own flop and follows its request one edge
  // later; no enable waits on another, so ports start together.
  for (genvar t = 0; t < `RPI_NUM_PORTS; t++) begin : g_tx_en_pin
    logic en_q, en_d;

    always_comb begin
      en_d = tx_port_req[t];
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        en_q <= 1'b0;
      end else begin
        en_q <= en_d;
      end
    end

    assign port_transmit_enable[t] = en_q;
  end : g_tx_en_pin

  // Busy has a flop of its own fed by the same requests, so it is high
  // exactly while any enable flop is set and carries no decode glitch.
  always_comb begin
    busy_d = |tx_port_req;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // A violation asked for while no port transmits is dropped, so the
  // marker never stands on an idle transmit bus. The nibble is passed on
  // whatever the enables, since an idle chip ignores it.
  always_comb begin
    txd_d  = tx_nib_in;
    txer_d = tx_viol_in && (|tx_port_req);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txd_q  <= 4'h0;
      txer_q <= 1'b0;
    end else begin
      txd_q  <= txd_d;
      txer_q <= txer_d;
    end
  end

  assign tx_busy = busy_q;
  assign tx_er   = txer_q;
  assign txd     = txd_q;
endmodule : rpi_phy_port

// ==== test/rpi_phy_port_checker.sv ====
// Port checks on the PHY port block, bound to every instance.
// Assumes the strap stays steady from reset onward.
`timescale 1ns/1ps
module rpi_phy_port_checker (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire rpi_pkg::rpi_port_vec_t crs, // Carrier
  input wire logic receive_enable_polarity_strap, // Strap
  input wire rpi_pkg::rpi_port_vec_t port_receive_output_enable, // Rx en
  input wire rpi_pkg::rpi_port_vec_t tx_port_req, // Request
  input wire rpi_pkg::rpi_nibble_t tx_nib_in, // Nibble
  input wire logic tx_viol_in, // Violation
  input wire rpi_pkg::rpi_port_vec_t port_transmit_enable, // Tx en
  input wire logic tx_busy, // Busy
  input wire logic tx_er, // Tx error
  input wire rpi_pkg::rpi_nibble_t txd, // Tx nibble
  input wire logic ir_valid, // Rx pulse
  input wire logic [3:0] rx_port // Port
);
  import rpi_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rpi_port_vec_t act;
  logic [2:0] up_q;
  logic [2:0] up_d;
  assign act = port_receive_output_enable
    ^ {12{~receive_enable_polarity_strap}};
  // Waits until strap and synchronisers have settled.
  always_comb up_d = rst ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
  always_ff @(posedge clk) up_q <= up_d;
  sequence s_run; !$past(rst); endsequence
  property p_busy; tx_busy == (|port_transmit_enable); endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_txe; s_run |-> port_transmit_enable == $past(tx_port_req);
  endproperty
  a_txe: assert property (p_txe) else $error("tx enable");
  property p_txd; s_run |-> txd == $past(tx_nib_in); endproperty
  a_txd: assert property (p_txd) else $error("tx nibble");
  property p_txer;
    s_run |-> tx_er == ($past(tx_viol_in) && |$past(tx_port_req));
  endproperty
  a_txer: assert property (p_txer) else $error("tx error");
  property p_one; up_q == 3'h7 |-> $onehot0(act); endproperty
  a_one: assert property (p_one) else $error("two enables");
  property p_crs; up_q == 3'h7 |-> (act & ~($past(crs, 1) | $past(crs, 2)
    | $past(crs, 3) | $past(crs, 4) | $past(crs, 5))) == 12'h000;
  endproperty
  a_crs: assert property (p_crs) else $error("no carrier");
  property p_sel; up_q == 3'h7 && $onehot(act) |-> act[rx_port];
  endproperty
  a_sel: assert property (p_sel) else $error("port");
  property p_pulse; ir_valid |=> !ir_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
endmodule : rpi_phy_port_checker
bind rpi_phy_port rpi_phy_port_checker u_chk (.*);

// ==== test/rpi_phy_model.sv ====
// Behavioural PHY chip on the shared receive bus.
// Assumes the bench calls tick and send; the clock idles low.
`timescale 1ns/1ps
module rpi_phy_model (
  output logic rx_clk, // Receive clock
  output rpi_pkg::rpi_nibble_t rxd, // Nibble
  output logic rx_dv, // Valid
  output logic rx_er // Error
);
  initial {rx_clk, rxd, rx_dv, rx_er} = 7'h00;
  task automatic tick(input int n);
    repeat (n) begin
      #3 rx_clk = 1'b1;
      #3 rx_clk = 1'b0;
    end
  endtask : tick
  // A released bus shows inverted data, never the last nibble.
  task automatic send(input rpi_pkg::rpi_nibble_t nib, input logic er);
    {rxd, rx_dv, rx_er} = {nib, 1'b1, er};
    tick(1);
    {rxd, rx_dv, rx_er} = {~nib, 2'b00};
    #200;
  endtask : send
endmodule : rpi_phy_model

// ==== test/rpi_phy_port_tb_top.sv ====
// Bench for the PHY port block against a behavioural PHY.
// Assumes the checker and PHY model are compiled first.
`timescale 1ns/1ps
module rpi_phy_port_tb_top;
  import rpi_pkg::*;
  logic clk, rst, rx_clk, rx_rst, rx_dv, rx_er, tx_viol_in, tx_busy, tx_er;
  logic ir_valid, ir_err, receive_enable_polarity_strap, tx_on;
  rpi_nibble_t rxd, tx_nib_in, txd, ir_nib;
  rpi_port_vec_t crs, port_receive_output_enable, tx_port_req;
  rpi_port_vec_t port_transmit_enable;
  logic [3:0] rx_port;
  logic [17:0] t_exp;
  int n_fail = 0, check_count = 0, n_seen = 0;
  logic [4:0] exp_q[$];
  wire [17:0] t_got = {port_transmit_enable, txd, tx_er, tx_busy};
  rpi_phy_port u_rpi_phy_port (.*);
  rpi_phy_model u_rpi_phy_model (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic ok, input string m);
    check_count++;
    if (!ok) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    if (tx_on) check(t_got === t_exp, "tx");
    t_exp = {tx_port_req, tx_nib_in, tx_viol_in & |tx_port_req, |tx_port_req};
    if (ir_valid) begin
      n_seen++;
      check({ir_err, ir_nib} === exp_q[0], "rx");
      if (exp_q.size() > 0) exp_q.delete(0);
    end
  end
  task automatic wait_en(input rpi_port_vec_t e);
    for (int k = 0; k < 20 && port_receive_output_enable !== e; k++)
      @(posedge clk);
    check(port_receive_output_enable === e, "enable");
    if (port_receive_output_enable !== e) finish_test();
  endtask : wait_en
  task automatic run_test(input logic s);
    int p;
    int q;
    int n0;
    logic [4:0] v;
    @(posedge clk);
    tx_on = 1'b0;
    {rst, rx_rst, crs, receive_enable_polarity_strap} <= {2'b11, 12'h0, s};
    u_rpi_phy_model.tick(4);
    repeat (6) @(posedge clk);
    {rst, rx_rst} <= 2'b00;
    repeat (4) @(posedge clk);
    tx_on = 1'b1;
    check(port_receive_output_enable === {12{~s}}, "idle");
    p = $urandom_range(11, 1);
    q = $urandom_range(p - 1, 0);
    crs <= 12'h001 << p;
    wait_en({12{~s}} ^ (12'h001 << p));
    check(rx_port === 4'(p), "port");
    crs <= (12'h001 << p) | (12'h001 << q);
    for (int k = 0; k < 6; k++) begin
      v = {k[0], k[0] ? {2'b00, k[1], 1'b0} : 4'($urandom)};
      exp_q.push_back(v);
      @(posedge clk);
      {tx_port_req, tx_nib_in, tx_viol_in} <= 17'($urandom)
        & {{12{k > 1}}, 5'h1f};
      u_rpi_phy_model.send(v[3:0], v[4]);
    end
    check(exp_q.size() == 0, "lost");
    @(posedge clk);
    crs <= 12'h001 << q;
    wait_en({12{~s}} ^ (12'h001 << q));
    crs <= 12'h000;
    wait_en({12{~s}});
    n0 = n_seen;
    u_rpi_phy_model.send(4'h5, 1'b0);
    check(n_seen == n0, "no enable");
    $display("test done, strap %0d", s);
  endtask : run_test
  initial begin
    {rst, rx_rst, receive_enable_polarity_strap, tx_on} = 4'he;
    {crs, tx_port_req, tx_nib_in, tx_viol_in} = 29'h0;
    void'($urandom(95363));
    run_test(1'b1);
    run_test(1'b0);
    finish_test();
  end
endmodule : rpi_phy_port_tb_top
